// File: ipc_top.sv
// Interrupt priority controller with AXI4-Lite registers and handler stack
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module ipc_top
  import ipc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [IPC_NSRC-1:0] src_event,
  input wire logic [IPC_NTRAP-1:0] trap_event,
  input wire logic irq_ack,
  input wire logic [IPC_PC_W-1:0] ack_pc,
  input wire logic srl_wr,
  input wire logic [7:0] srl_wdata,
  input wire logic return_from_interrupt,
  input wire logic timed_disable_instr,
  input wire logic [IPC_TIMED_DISABLE_INSTR_W-1:0] timed_disable_instr_count,
  output logic irq_req,
  output logic [4:0] irq_vec,
  output logic [3:0] irq_lvl,
  output logic [7:0] status_low_byte,
  output logic [3:0] cpu_lvl,
  output logic ret_valid,
  output logic [IPC_PC_W-1:0] ret_pc,
  output logic timed_disable_instr_busy
);
  // Bus slave state
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
  logic [7:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic wr_go;
  logic [32:0] wr_cur, rd_cur;
  logic [31:0] wval;
  // Register state
  logic [IPC_NSRC-1:0] flag_ff, nxt_flag, en_ff, nxt_en;
  logic [31:0] prio0_ff, nxt_prio0, prio1_ff, nxt_prio1;
  logic nest_ff, nxt_nest;
  logic [IPC_NTRAP-1:0] trap_ff, nxt_trap;
  // Core side state
  logic [7:0] srl_ff, nxt_srl;
  logic [3:0] lvl_ff, nxt_lvl, depth_ff, nxt_depth;
  logic [IPC_PC_W-1:0] stk_pc_ff [IPC_STK_N], nxt_stk_pc [IPC_STK_N];
  logic [7:0] stk_srl_ff [IPC_STK_N], nxt_stk_srl [IPC_STK_N];
  logic [3:0] stk_lvl_ff [IPC_STK_N], nxt_stk_lvl [IPC_STK_N];
  logic ret_valid_ff, nxt_ret_valid, irq_req_ff, nxt_irq_req, timed_disable_instr_busy_ff, nxt_timed_disable_instr_busy;
  logic [IPC_PC_W-1:0] ret_pc_ff, nxt_ret_pc;
  logic [4:0] irq_vec_ff;
  logic [3:0] irq_lvl_ff;
  logic [IPC_TIMED_DISABLE_INSTR_W-1:0] timed_disable_instr_ff, nxt_timed_disable_instr;
  // Arbitration
  logic win_valid, win_ok, take, pop;
  logic [3:0] win_lvl, thr_user;
  logic [4:0] win_id;
  logic [2:0] pop_idx;
  logic [IPC_PC_W-1:0] top_pc;
  logic [3:0] top_lvl;

  // Register read view: hit flag on top of the word
  function automatic logic [32:0] reg_view(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      OFS_FLAG: r[15:0] = flag_ff;
      OFS_EN: r[15:0] = en_ff;
      OFS_PRIO0: r[31:0] = prio0_ff;
      OFS_PRIO1: r[31:0] = prio1_ff;
      OFS_CTRL1: begin
        r[NEST_BIT] = nest_ff;
        r[IPC_NTRAP-1:0] = trap_ff;
      end
      OFS_STAT: begin
        r[3:0] = lvl_ff;
        r[STAT_TIMED_DISABLE_INSTR_BIT] = timed_disable_instr_busy_ff;
        r[STAT_DEPTH_LSB +: 4] = depth_ff;
      end
      default: r = 33'h0_0000_0000;
    endcase
    return r;
  endfunction : reg_view

  // Byte-lane merge of a write into the current word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  ipc_resolve u_resolve (
    .flag(flag_ff),
    .en(en_ff),
    .prio({prio1_ff, prio0_ff}),
    .trap_flag(trap_ff),
    .best_valid(win_valid),
    .best_lvl(win_lvl),
    .best_id(win_id)
  );

  // Bus handshakes: address and data taken in either order, answer after both
  always_comb begin
    nxt_aw_ok = aw_ok_ff;
    nxt_w_ok = w_ok_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    wr_go = 1'b0;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_ok = 1'b1;
      nxt_waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_ok = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (aw_ok_ff && w_ok_ff && !bvalid_ff) begin
      wr_go = 1'b1;
      nxt_aw_ok = 1'b0;
      nxt_w_ok = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = wr_cur[32] ? RESP_OKAY : RESP_SLVERR; // Unmapped answers SLVERR
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_ok && !nxt_bvalid;
    nxt_wready = !nxt_w_ok && !nxt_bvalid;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rdata = rd_cur[31:0];
      nxt_rresp = rd_cur[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  assign wr_cur = reg_view(waddr_ff);
  assign rd_cur = reg_view(s_axi_araddr);
  assign wval = merge(wr_cur[31:0], wdata_ff, wstrb_ff);

  // Register writes; hardware events set flags after the write so a set wins
  always_comb begin
    nxt_flag = flag_ff;
    nxt_en = en_ff;
    nxt_prio0 = prio0_ff;
    nxt_prio1 = prio1_ff;
    nxt_nest = nest_ff;
    nxt_trap = trap_ff;
    if (wr_go) begin
      case (waddr_ff)
        OFS_FLAG: nxt_flag = wval[15:0];
        OFS_EN: nxt_en = wval[15:0];
        OFS_PRIO0: nxt_prio0 = wval & PRIO_MASK;
        OFS_PRIO1: nxt_prio1 = wval & PRIO_MASK;
        OFS_CTRL1: begin
          nxt_nest = wval[NEST_BIT];
          nxt_trap = trap_ff & wval[IPC_NTRAP-1:0]; // Writing zero clears
        end
        default: nxt_flag = flag_ff;
      endcase
    end
    nxt_flag = nxt_flag | src_event;
    nxt_trap = nxt_trap | trap_event;
  end

  // Thresholds and the take decision
  always_comb begin
    thr_user = lvl_ff;
    if (timed_disable_instr_ff != '0 && thr_user < LVL_TIMED_DISABLE_INSTR_CEIL) begin
      thr_user = LVL_TIMED_DISABLE_INSTR_CEIL;
    end
    if (nest_ff && depth_ff != 4'h0) begin
      thr_user = LVL_USER_MAX;
    end
  end

  assign win_ok = win_valid && depth_ff != 4'(IPC_STK_N) &&
                  (win_id[4] ? (win_lvl > lvl_ff) : (win_lvl > thr_user));
  assign take = irq_ack && irq_req_ff;
  assign pop = return_from_interrupt && !take && depth_ff != 4'h0;
  assign pop_idx = 3'(depth_ff - 4'h1);
  assign top_pc = stk_pc_ff[pop_idx];
  assign top_lvl = stk_lvl_ff[pop_idx];

  // Handler entry pushes, return pops, core writes the status byte
  always_comb begin
    nxt_srl = srl_ff;
    nxt_lvl = lvl_ff;
    nxt_depth = depth_ff;
    nxt_stk_pc = stk_pc_ff;
    nxt_stk_srl = stk_srl_ff;
    nxt_stk_lvl = stk_lvl_ff;
    nxt_ret_valid = 1'b0;
    nxt_ret_pc = ret_pc_ff;
    if (take) begin
      nxt_stk_pc[depth_ff[2:0]] = ack_pc;
      nxt_stk_srl[depth_ff[2:0]] = srl_ff;
      nxt_stk_lvl[depth_ff[2:0]] = lvl_ff;
      nxt_depth = depth_ff + 4'h1;
      nxt_lvl = irq_lvl_ff;
      nxt_srl[SRL_IPL_LSB +: 3] = irq_lvl_ff[2:0];
    end else if (pop) begin
      nxt_ret_valid = 1'b1;
      nxt_ret_pc = top_pc;
      nxt_srl = stk_srl_ff[pop_idx];
      nxt_lvl = top_lvl;
      nxt_depth = depth_ff - 4'h1;
    end else if (srl_wr) begin
      nxt_srl = srl_wdata;
      nxt_lvl = {lvl_ff[3], srl_wdata[SRL_IPL_LSB +: 3]};
    end
    nxt_irq_req = win_ok && !irq_ack;
    nxt_timed_disable_instr = timed_disable_instr_ff;
    if (timed_disable_instr) begin
      nxt_timed_disable_instr = timed_disable_instr_count;
    end else if (timed_disable_instr_ff != '0) begin
      nxt_timed_disable_instr = timed_disable_instr_ff - IPC_TIMED_DISABLE_INSTR_W'(1);
    end
    nxt_timed_disable_instr_busy = nxt_timed_disable_instr != '0;
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      waddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
      flag_ff <= RST_FLAG;
      en_ff <= RST_EN;
      prio0_ff <= RST_PRIO;
      prio1_ff <= RST_PRIO;
      nest_ff <= 1'b0;
      trap_ff <= '0;
      srl_ff <= RST_SRL;
      lvl_ff <= 4'h0;
      depth_ff <= 4'h0;
      ret_valid_ff <= 1'b0;
      ret_pc_ff <= '0;
      irq_req_ff <= 1'b0;
      irq_vec_ff <= 5'h00;
      irq_lvl_ff <= 4'h0;
      timed_disable_instr_ff <= '0;
      timed_disable_instr_busy_ff <= 1'b0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_ok_ff <= nxt_aw_ok;
      w_ok_ff <= nxt_w_ok;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      flag_ff <= nxt_flag;
      en_ff <= nxt_en;
      prio0_ff <= nxt_prio0;
      prio1_ff <= nxt_prio1;
      nest_ff <= nxt_nest;
      trap_ff <= nxt_trap;
      srl_ff <= nxt_srl;
      lvl_ff <= nxt_lvl;
      depth_ff <= nxt_depth;
      ret_valid_ff <= nxt_ret_valid;
      ret_pc_ff <= nxt_ret_pc;
      irq_req_ff <= nxt_irq_req;
      irq_vec_ff <= win_id;
      irq_lvl_ff <= win_lvl;
      timed_disable_instr_ff <= nxt_timed_disable_instr;
      timed_disable_instr_busy_ff <= nxt_timed_disable_instr_busy;
    end
  end

  // Stack storage carries no reset
  always_ff @(posedge aclk) begin
    stk_pc_ff <= nxt_stk_pc;
    stk_srl_ff <= nxt_stk_srl;
    stk_lvl_ff <= nxt_stk_lvl;
  end

  // Outputs
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign irq_req = irq_req_ff;
  assign irq_vec = irq_vec_ff;
  assign irq_lvl = irq_lvl_ff;
  assign status_low_byte = srl_ff;
  assign cpu_lvl = lvl_ff;
  assign ret_valid = ret_valid_ff;
  assign ret_pc = ret_pc_ff;
  assign timed_disable_instr_busy = timed_disable_instr_busy_ff;

  // Checks
  sequence s_take;
    irq_ack && irq_req_ff;
  endsequence
  sequence s_raised;
    lvl_ff == $past(irq_lvl_ff) && depth_ff == $past(depth_ff) + 4'h1;
  endsequence
  sequence s_popped;
    ret_valid_ff && ret_pc_ff == $past(top_pc) && lvl_ff == $past(top_lvl);
  endsequence

  a_ack_raise_lvl: assert property (@(posedge aclk) disable iff (!aresetn)
    s_take |=> s_raised) else $error("entry did not raise cpu level");
  a_ret_restore: assert property (@(posedge aclk) disable iff (!aresetn)
    pop |=> s_popped) else $error("return did not restore state");
  a_above_cpu: assert property (@(posedge aclk) disable iff (!aresetn)
    win_ok |-> win_lvl > lvl_ff) else $error("request not above cpu level");
  a_req_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    win_ok && !irq_ack |=> irq_req_ff && irq_vec_ff == $past(win_id))
    else $error("request not raised");
  a_nest_block: assert property (@(posedge aclk) disable iff (!aresetn)
    nest_ff && depth_ff != 4'h0 && win_ok |-> win_id[4]) else $error("nested user entry");
  a_prio_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> prio0_ff == RST_PRIO && prio1_ff == RST_PRIO)
    else $error("priority reset wrong");
  a_en_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    win_ok && !win_id[4] |-> en_ff[win_id[3:0]] && flag_ff[win_id[3:0]])
    else $error("disabled source requested");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(wr_go) |-> (flag_ff & $past(flag_ff)) == $past(flag_ff))
    else $error("flag dropped without write");
  a_trap_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(wr_go) |-> (trap_ff & $past(trap_ff)) == $past(trap_ff))
    else $error("trap flag dropped without write");
  a_ipl7_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    lvl_ff >= LVL_USER_MAX && win_ok |-> win_id[4]) else $error("user passed level seven");
  a_trap_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    trap_ff != '0 && lvl_ff < LVL_TRAP_BASE && depth_ff != 4'(IPC_STK_N) |-> win_ok && win_id[4])
    else $error("trap masked");
  a_timed_disable_instr_mask: assert property (@(posedge aclk) disable iff (!aresetn)
    timed_disable_instr_ff != '0 && win_ok && !win_id[4] |-> win_lvl == LVL_USER_MAX)
    else $error("timed disable leaked");
endmodule : ipc_top

// File: ipc_pkg.sv
// Constants shared by the interrupt priority controller and its resolver
package ipc_pkg;
  // Sizes
  localparam int IPC_NSRC = 16;
  localparam int IPC_NTRAP = 8;
  localparam int IPC_STK_N = 8;
  localparam int IPC_PRIO_W = 3;
  localparam int IPC_NIB_W = 4;
  localparam int IPC_PC_W = 24;
  localparam int IPC_TIMED_DISABLE_INSTR_W = 14;
  // Register byte offsets
  localparam logic [7:0] OFS_FLAG = 8'h00;
  localparam logic [7:0] OFS_EN = 8'h04;
  localparam logic [7:0] OFS_PRIO0 = 8'h08;
  localparam logic [7:0] OFS_PRIO1 = 8'h0C;
  localparam logic [7:0] OFS_CTRL1 = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  // Reset values and masks
  localparam logic [31:0] RST_PRIO = 32'h4444_4444;
  localparam logic [31:0] PRIO_MASK = 32'h7777_7777;
  localparam logic [15:0] RST_FLAG = 16'h0000;
  localparam logic [15:0] RST_EN = 16'h0000;
  localparam logic [7:0] RST_SRL = 8'h00;
  // Field positions
  localparam int NEST_BIT = 15;
  localparam int SRL_IPL_LSB = 1;
  localparam int STAT_TIMED_DISABLE_INSTR_BIT = 4;
  localparam int STAT_DEPTH_LSB = 8;
  // Priority levels
  localparam logic [3:0] LVL_TIMED_DISABLE_INSTR_CEIL = 4'h6;
  localparam logic [3:0] LVL_USER_MAX = 4'h7;
  localparam logic [3:0] LVL_TRAP_BASE = 4'h8;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ipc_pkg

// File: ipc_resolve.sv
// Combinational winner search over user sources and traps
`timescale 1ns/1ps
module ipc_resolve
  import ipc_pkg::*;
(
  input wire logic [IPC_NSRC-1:0] flag,
  input wire logic [IPC_NSRC-1:0] en,
  input wire logic [63:0] prio,
  input wire logic [IPC_NTRAP-1:0] trap_flag,
  output logic best_valid,
  output logic [3:0] best_lvl,
  output logic [4:0] best_id
);
  logic [IPC_PRIO_W-1:0] src_lvl [IPC_NSRC];

  // Effective level per source: zero when not flagged, not enabled or field is zero
  generate
    for (genvar i = 0; i < IPC_NSRC; i++) begin : g_src
      assign src_lvl[i] = (flag[i] && en[i]) ? prio[i*IPC_NIB_W +: IPC_PRIO_W]
                                             : '0;
    end
  endgenerate

  // Highest level wins; equal levels go to the lowest index
  always_comb begin
    best_valid = 1'b0;
    best_lvl = 4'h0;
    best_id = 5'h00;
    for (int i = 0; i < IPC_NSRC; i++) begin
      if ({1'b0, src_lvl[i]} > best_lvl) begin
        best_valid = 1'b1;
        best_lvl = {1'b0, src_lvl[i]};
        best_id = 5'(i);
      end
    end
    // Traps sit above every user level, higher index is higher level
    for (int t = 0; t < IPC_NTRAP; t++) begin
      if (trap_flag[t]) begin
        best_valid = 1'b1;
        best_lvl = LVL_TRAP_BASE + 4'(t);
        best_id = 5'(IPC_NSRC + t);
      end
    end
  end
endmodule : ipc_resolve

// File: ipc_core_model.sv
// CPU core model that takes offered requests after a set wait
`timescale 1ns/1ps
module ipc_core_model
  import ipc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  input wire logic irq_req,
  input wire logic [4:0] irq_vec,
  output logic irq_ack,
  output logic [IPC_PC_W-1:0] ack_pc
);
  logic [3:0] cnt;
  // Defined idle values before the first edge
  initial begin
    irq_ack = 1'b0;
    ack_pc = '0;
    cnt = 4'h0;
  end
  // One-cycle acknowledge; the saved PC is only meaningful beside it
  always @(posedge aclk) begin
    irq_ack <= 1'b0;
    ack_pc <= ~ack_pc;
    if (!aresetn || !irq_req || irq_ack) begin
      cnt <= 4'h0;
    end else if (ack_en && cnt >= ack_wait) begin
      irq_ack <= 1'b1;
      ack_pc <= {16'h0010, 3'b000, irq_vec};
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : ipc_core_model

// File: test_interrupt_priority_control.sv
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
module test_interrupt_priority_control import ipc_pkg::*; ;
  logic aclk = 1'b0, aresetn = 1'b0, ack_en = 1'b0, srl_wr = 1'b0;
  logic return_from_interrupt = 1'b0, timed_disable_instr = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, srl_wdata = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0, ack_wait = 4'h0, irq_lvl, cpu_lvl;
  logic [15:0] src_event = 16'h0000;
  logic [7:0] trap_event = 8'h00, status_low_byte;
  logic [13:0] timed_disable_instr_count = 14'h0000;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic irq_req, irq_ack, ret_valid, timed_disable_instr_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] irq_vec;
  logic [IPC_PC_W-1:0] ack_pc, ret_pc;
  int n_fail = 0, compares = 0, cycles = 0;

  ipc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_event, .trap_event,
    .irq_ack, .ack_pc, .srl_wr, .srl_wdata, .return_from_interrupt, .timed_disable_instr,
    .timed_disable_instr_count, .irq_req, .irq_vec, .irq_lvl, .status_low_byte, .cpu_lvl, .ret_valid,
    .ret_pc, .timed_disable_instr_busy);
  ipc_core_model core (.aclk, .aresetn, .ack_en, .ack_wait, .irq_req, .irq_vec,
    .irq_ack, .ack_pc);

  // Clock and hang guard
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  // Value comparison with report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  // Bus read with data and response comparison
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    chk("rdata", exp, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd

  // Sampling point just after an edge
  task automatic step;
    @(posedge aclk);
    #1;
  endtask : step

  task automatic exp_req(input logic [4:0] v, input logic [3:0] l);
    int n = 0;
    do begin
      step();
      n++;
    end while (irq_req !== 1'b1 && n < 12);
    chk("irq_req", 32'h0000_0001, 32'(irq_req));
    chk("irq_vec", 32'(v), 32'(irq_vec));
    chk("irq_lvl", 32'(l), 32'(irq_lvl));
  endtask : exp_req

  task automatic no_req(input int n);
    logic seen = 1'b0;
    repeat (n) begin
      step();
      seen = seen | irq_req;
    end
    chk("irq_req", 32'h0000_0000, 32'(seen));
  endtask : no_req

  task automatic wait_lvl(input logic [3:0] l);
    int n = 0;
    while (cpu_lvl !== l && n < 20) begin
      step();
      n++;
    end
    chk("cpu_lvl", 32'(l), 32'(cpu_lvl));
  endtask : wait_lvl

  task automatic pulse_src(input int i);
    @(posedge aclk);
    src_event <= 16'h0001 << i;
    @(posedge aclk);
    src_event <= 16'h0000;
  endtask : pulse_src

  task automatic set_srl(input logic [7:0] v);
    @(posedge aclk);
    srl_wr <= 1'b1;
    srl_wdata <= v;
    @(posedge aclk);
    srl_wr <= 1'b0;
  endtask : set_srl

  // Return and check what the stack gives back
  task automatic do_return(input logic [IPC_PC_W-1:0] pc, input logic [3:0] l);
    @(posedge aclk);
    return_from_interrupt <= 1'b1;
    @(posedge aclk);
    return_from_interrupt <= 1'b0;
    #1;
    chk("ret_valid", 32'h0000_0001, 32'(ret_valid));
    chk("ret_pc", 32'(pc), 32'(ret_pc));
    chk("cpu_lvl", 32'(l), 32'(cpu_lvl));
    chk("srl", 32'({l[2:0], 1'b0}), 32'(status_low_byte));
  endtask : do_return

  task automatic set_ack(input logic e, input logic [3:0] w);
    @(posedge aclk);
    ack_en <= e;
    ack_wait <= w;
  endtask : set_ack

  // Reset values, masked fields and an unmapped offset
  task automatic t_regs;
    rd(OFS_PRIO0, RST_PRIO, RESP_OKAY);
    rd(OFS_PRIO1, RST_PRIO, RESP_OKAY);
    rd(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    rd(OFS_STAT, 32'h0000_0000, RESP_OKAY);
    wr(OFS_PRIO1, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_PRIO1, PRIO_MASK, RESP_OKAY);
    wr(8'h18, 32'h0000_0001, RESP_SLVERR);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    wr(OFS_PRIO1, RST_PRIO, RESP_OKAY);
  endtask : t_regs

  // Enable gating, take, sticky flag and re-entry after return
  task automatic t_basic;
    wr(OFS_EN, 32'h0000_0008, RESP_OKAY);
    pulse_src(5);
    no_req(6);
    rd(OFS_FLAG, 32'h0000_0020, RESP_OKAY);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    pulse_src(3);
    exp_req(5'd3, 4'h4);
    set_ack(1'b1, 4'h2);
    wait_lvl(4'h4);
    chk("srl", 32'h0000_0008, 32'(status_low_byte));
    no_req(4);
    rd(OFS_FLAG, 32'h0000_0008, RESP_OKAY);
    do_return(24'h00_1003, 4'h0);
    wait_lvl(4'h4);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    do_return(24'h00_1003, 4'h0);
    no_req(4);
    set_ack(1'b0, 4'h0);
    wr(OFS_EN, 32'h0000_0000, RESP_OKAY);
  endtask : t_basic

  // Distinct, shared and disabled priority fields
  task automatic t_prio;
    wr(OFS_PRIO0, 32'h0000_0620, RESP_OKAY);
    wr(OFS_EN, 32'h0000_0006, RESP_OKAY);
    pulse_src(1);
    pulse_src(2);
    exp_req(5'd2, 4'h6);
    wr(OFS_PRIO0, 32'h0000_0020, RESP_OKAY);
    exp_req(5'd1, 4'h2);
    wr(OFS_PRIO0, 32'h0000_0220, RESP_OKAY);
    exp_req(5'd1, 4'h2);
    wr(OFS_PRIO0, 32'h0000_0000, RESP_OKAY);
    no_req(4);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    wr(OFS_PRIO0, RST_PRIO, RESP_OKAY);
  endtask : t_prio

  // CPU level seven masks users; a trap still enters and re-enters
  task automatic t_mask;
    wr(OFS_PRIO0, 32'h4444_4447, RESP_OKAY);
    wr(OFS_EN, 32'h0000_0001, RESP_OKAY);
    set_srl(status_low_byte | 8'h0E);
    wait_lvl(4'h7);
    pulse_src(0);
    no_req(6);
    set_ack(1'b1, 4'h0);
    @(posedge aclk);
    trap_event <= 8'h04;
    @(posedge aclk);
    trap_event <= 8'h00;
    wait_lvl(4'hA);
    rd(OFS_CTRL1, 32'h0000_0004, RESP_OKAY);
    do_return(24'h00_1012, 4'h7);
    wait_lvl(4'hA);
    wr(OFS_CTRL1, 32'h0000_00FB, RESP_OKAY);
    do_return(24'h00_1012, 4'h7);
    no_req(4);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    set_srl(8'h00);
    set_ack(1'b0, 4'h0);
    wr(OFS_PRIO0, RST_PRIO, RESP_OKAY);
  endtask : t_mask

  // Nesting disabled blocks a higher source until the bit is cleared
  task automatic t_nest;
    wr(OFS_CTRL1, 32'h0000_80FF, RESP_OKAY);
    wr(OFS_PRIO0, 32'h4444_4447, RESP_OKAY);
    wr(OFS_EN, 32'h0000_0003, RESP_OKAY);
    set_ack(1'b1, 4'h1);
    pulse_src(1);
    wait_lvl(4'h4);
    pulse_src(0);
    no_req(6);
    wr(OFS_CTRL1, 32'h0000_00FF, RESP_OKAY);
    wait_lvl(4'h7);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    do_return(24'h00_1000, 4'h4);
    do_return(24'h00_1001, 4'h0);
    set_ack(1'b0, 4'h0);
    wr(OFS_PRIO0, RST_PRIO, RESP_OKAY);
  endtask : t_nest

  // Timed disable holds off levels up to six but not seven
  task automatic t_timed_disable_instr;
    int n = 0;
    wr(OFS_PRIO0, 32'h4444_4760, RESP_OKAY);
    wr(OFS_EN, 32'h0000_0006, RESP_OKAY);
    @(posedge aclk);
    timed_disable_instr <= 1'b1;
    timed_disable_instr_count <= 14'h0028;
    @(posedge aclk);
    timed_disable_instr <= 1'b0;
    pulse_src(1);
    no_req(4);
    chk("timed_disable_instr_busy", 32'h0000_0001, 32'(timed_disable_instr_busy));
    pulse_src(2);
    exp_req(5'd2, 4'h7);
    wr(OFS_FLAG, 32'h0000_0002, RESP_OKAY);
    while (timed_disable_instr_busy !== 1'b0 && n < 60) begin
      step();
      n++;
    end
    exp_req(5'd1, 4'h6);
    wr(OFS_FLAG, 32'h0000_0000, RESP_OKAY);
    wr(OFS_EN, 32'h0000_0000, RESP_OKAY);
  endtask : t_timed_disable_instr

  task automatic finish_test;
    $display("TB: compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  // Reset, then the scenarios in turn
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_basic();
    t_prio();
    t_mask();
    t_nest();
    t_timed_disable_instr();
    finish_test();
  end
endmodule : test_interrupt_priority_control
